// >>> rtl/sgs_gain_selector.sv
/*
  Servo gain set selector: picks base, alternate 1 or alternate 2 gains from
  command bits, input devices or a measured level, filters the hand-over,
  reports the active set and raises an interrupt on each change.
  Assumes all inputs synchronous to sys_clk and ctrlTick one cycle per loop.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "sgs_defines.svh"
module sgs_gain_selector (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic ctrlTick,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic altSet1Input,
  input wire logic altSet2Input,
  input wire logic signed [15:0] motorSpeed,
  input wire logic signed [15:0] cmdFrequency,
  input wire logic signed [15:0] droopPulses,
  input wire sgs_pkg::sgs_gain_t baseGains,
  input wire sgs_pkg::sgs_gain_t set1Gains,
  input wire sgs_pkg::sgs_gain_t set2Gains,
  output sgs_pkg::sgs_gain_t activeGains,
  output logic altSet1ActiveFlag,
  output logic altSet2ActiveFlag,
  output logic irq
);

  // Magnitude of a signed quantity, full range kept
  function automatic logic [15:0] absVal(input logic signed [15:0] v);
    logic [16:0] neg;
    neg = 17'h00000 - {v[15], v};
    absVal = v[15] ? neg[15:0] : v;
  endfunction : absVal

  // One step of the first-order switching filter; shift 0 means no filter
  function automatic logic [15:0] filtStep(input logic [15:0] cur,
                                           input logic [15:0] tgt,
                                           input logic [3:0] tc);
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic [16:0] sum;
    diff = $signed({1'b0, tgt}) - $signed({1'b0, cur});
    step = diff >>> tc;
    sum = {1'b0, cur} + step;
    // A step that rounds to zero would never arrive, so snap
    if (tc == 4'h0 || step == 17'sh00000)
      filtStep = tgt;
    else
      filtStep = sum[15:0];
  endfunction : filtStep

  // Level comparison for the level driven sources
  function automatic sgs_pkg::sgs_set_e levelSel(input logic below,
                                                  input logic use2,
                                                  input logic [15:0] l1,
                                                  input logic [15:0] l2,
                                                  input logic [15:0] v);
    logic no2;
    no2 = !use2 || l2 == `SGS_RST_WORD;
    levelSel = sgs_pkg::SET_BASE;
    if (!below) begin
      // Above level polarity
      if (no2)
        levelSel = (v > l1) ? sgs_pkg::SET_ALT1 : sgs_pkg::SET_BASE;
      else if (l2 >= l1) begin
        if (v > l2)
          levelSel = sgs_pkg::SET_ALT2;
        else if (v > l1)
          levelSel = sgs_pkg::SET_ALT1;
      end else if (v > l2)
        levelSel = sgs_pkg::SET_ALT2;
    end else begin
      // Below level polarity
      if (no2)
        levelSel = (v < l1) ? sgs_pkg::SET_ALT1 : sgs_pkg::SET_BASE;
      else if (l2 <= l1) begin
        if (v < l2)
          levelSel = sgs_pkg::SET_ALT2;
        else if (v < l1)
          levelSel = sgs_pkg::SET_ALT1;
      end else if (v < l2)
        levelSel = sgs_pkg::SET_ALT2;
    end
  endfunction : levelSel

  sgs_pkg::sgs_state_s q; // Registered state
  sgs_pkg::sgs_state_s next_q; // Next state

  // Decoded configuration fields and derived combinational signals
  logic [2:0] src;
  logic below;
  logic [1:0] src2;
  logic [1:0] byp;
  logic sig1;
  logic sig2;
  logic [15:0] level;
  sgs_pkg::sgs_set_e sel;
  sgs_pkg::sgs_gain_t tgtGains;
  logic [3:0] tgtTc;
  logic direct;
  logic [15:0] stat1;
  logic [15:0] stat5;
  logic [2:0] events;

  assign src = q.cfg[`SGS_CFG_SRC];
  assign below = q.cfg[`SGS_CFG_POL];
  assign src2 = q.cfg[`SGS_CFG_SRC2];
  assign byp = q.cfg[`SGS_CFG_BYP];

  // Switch signals: command bit or input device; polarity 1 means active off
  assign sig1 = (q.ctrl1[`SGS_SW_BIT] | altSet1Input) ^ below;
  assign sig2 = (q.ctrl5[`SGS_SW_BIT] | altSet2Input) ^ below;

  // Measured level by source code
  always_comb begin
    case (src)
      `SGS_SRC_FREQ: level = absVal(cmdFrequency);
      `SGS_SRC_DROOP: level = absVal(droopPulses);
      `SGS_SRC_SPEED: level = absVal(motorSpeed);
      default: level = `SGS_RST_WORD;
    endcase
  end

  // Candidate set for this control cycle
  always_comb begin
    sel = sgs_pkg::SET_BASE;
    case (src)
      `SGS_SRC_SIG: begin
        // Set 2 wins over set 1 while its signal is on
        if (src2 == `SGS_SRC2_SIG && sig2)
          sel = sgs_pkg::SET_ALT2;
        else if (sig1)
          sel = sgs_pkg::SET_ALT1;
        else
          sel = sgs_pkg::SET_BASE;
      end
      `SGS_SRC_FREQ, `SGS_SRC_DROOP, `SGS_SRC_SPEED: begin
        sel = levelSel(below, src2 == `SGS_SRC2_SAME, q.lvl1, q.lvl2, level);
        // Signal driven set 2 still overrides a level choice
        if (src2 == `SGS_SRC2_SIG && sig2)
          sel = sgs_pkg::SET_ALT2;
      end
      default: sel = sgs_pkg::SET_BASE;
    endcase
  end

  // Target bundle and filter constant; a return uses the leaving set's constant
  always_comb begin
    case (sel)
      sgs_pkg::SET_ALT1: begin
        tgtGains = set1Gains;
        tgtTc = q.tcs[`SGS_TC1];
      end
      sgs_pkg::SET_ALT2: begin
        tgtGains = set2Gains;
        tgtTc = q.tcs[`SGS_TC2];
      end
      default: begin
        tgtGains = baseGains;
        tgtTc = q.lastAlt2 ? q.tcs[`SGS_TC2] : q.tcs[`SGS_TC1];
      end
    endcase
  end

  // Filter bypass on the switching cycle only
  assign direct = (sel != q.active) &&
                  ((sel != sgs_pkg::SET_BASE && byp == `SGS_BYP_SWITCH) ||
                   (sel == sgs_pkg::SET_BASE && byp == `SGS_BYP_RETURN));

  // Set change events
  always_comb begin
    events = `SGS_RST_IRQ;
    if (ctrlTick && sel != q.active) begin
      events[`SGS_IRQ_ALT1] = sel == sgs_pkg::SET_ALT1;
      events[`SGS_IRQ_ALT2] = sel == sgs_pkg::SET_ALT2;
      events[`SGS_IRQ_BASE] = sel == sgs_pkg::SET_BASE;
    end
  end

  // Status words, only bit 4 is live
  always_comb begin
    stat1 = `SGS_RST_WORD;
    stat5 = `SGS_RST_WORD;
    stat1[`SGS_SW_BIT] = q.active == sgs_pkg::SET_ALT1;
    stat5[`SGS_SW_BIT] = q.active == sgs_pkg::SET_ALT2;
  end

  // Next state: register port, set resolution, filter, interrupt status
  always_comb begin
    next_q = q;
    // Writes; status words are read only
    if (regWr) begin
      case (regAddr)
        `SGS_OFF_CTRL1: next_q.ctrl1 = regWdata;
        `SGS_OFF_CTRL5: next_q.ctrl5 = regWdata;
        `SGS_OFF_CFG: next_q.cfg = regWdata[7:0];
        `SGS_OFF_LVL1: next_q.lvl1 = regWdata;
        `SGS_OFF_LVL2: next_q.lvl2 = regWdata;
        `SGS_OFF_TC: next_q.tcs = regWdata[7:0];
        `SGS_OFF_IRQMSK: next_q.irqMask = regWdata[2:0];
        default: ;
      endcase
    end
    // Read data stands only in the cycle after the strobe
    next_q.rdata = `SGS_RST_WORD;
    if (regRd) begin
      case (regAddr)
        `SGS_OFF_CTRL1: next_q.rdata = q.ctrl1;
        `SGS_OFF_CTRL5: next_q.rdata = q.ctrl5;
        `SGS_OFF_STAT1: next_q.rdata = stat1;
        `SGS_OFF_STAT5: next_q.rdata = stat5;
        `SGS_OFF_CFG: next_q.rdata = {8'h00, q.cfg};
        `SGS_OFF_LVL1: next_q.rdata = q.lvl1;
        `SGS_OFF_LVL2: next_q.rdata = q.lvl2;
        `SGS_OFF_TC: next_q.rdata = {8'h00, q.tcs};
        `SGS_OFF_IRQST: next_q.rdata = {13'h0000, q.irqStat};
        `SGS_OFF_IRQMSK: next_q.rdata = {13'h0000, q.irqMask};
        default: next_q.rdata = `SGS_RST_WORD;
      endcase
    end
    // Once per loop cycle the whole bundle moves together
    if (ctrlTick) begin
      next_q.active = sel;
      if (sel == sgs_pkg::SET_ALT1)
        next_q.lastAlt2 = 1'b0;
      else if (sel == sgs_pkg::SET_ALT2)
        next_q.lastAlt2 = 1'b1;
      for (int i = 0; i < 13; i++) begin
        if (direct)
          next_q.gains[i] = tgtGains[i];
        else
          next_q.gains[i] = filtStep(q.gains[i], tgtGains[i], tgtTc);
      end
    end
    // Write one clears, a new event in the same cycle wins
    next_q.irqStat = q.irqStat & ~((regWr && regAddr == `SGS_OFF_IRQST) ?
                                   regWdata[2:0] : `SGS_RST_IRQ);
    next_q.irqStat = next_q.irqStat | events;
  end

  // State register, frozen while ce is low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign regRdata = q.rdata;
  assign activeGains = q.gains;
  assign altSet1ActiveFlag = q.active == sgs_pkg::SET_ALT1;
  assign altSet2ActiveFlag = q.active == sgs_pkg::SET_ALT2;
  assign irq = |(q.irqStat & q.irqMask);

  // Set 2 command beats set 1 in signal mode
  chk_set2_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && src == `SGS_SRC_SIG && src2 == `SGS_SRC2_SIG && !below &&
    q.ctrl5[`SGS_SW_BIT] |=> q.active == sgs_pkg::SET_ALT2)
    else $error("set 2 command did not select set 2");

  // Both commands off returns to base
  chk_both_off_base: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && src == `SGS_SRC_SIG && !below && !altSet1Input &&
    !altSet2Input && !q.ctrl1[`SGS_SW_BIT] && !q.ctrl5[`SGS_SW_BIT]
    |=> q.active == sgs_pkg::SET_BASE)
    else $error("base set not restored");

  // Status read shows the active set one cycle later
  chk_status_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && regRd && regAddr == `SGS_OFF_STAT5
    |=> regRdata[`SGS_SW_BIT] == $past(q.active == sgs_pkg::SET_ALT2))
    else $error("status word five wrong");

  // Zero second level never yields set 2
  chk_zero_lvl2: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && src == `SGS_SRC_SPEED && src2 == `SGS_SRC2_SAME &&
    q.lvl2 == `SGS_RST_WORD |=> q.active != sgs_pkg::SET_ALT2)
    else $error("set 2 chosen with zero level");

  // Inverted levels above polarity never give set 1
  chk_above_no_set1: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && src == `SGS_SRC_SPEED && src2 == `SGS_SRC2_SAME && !below &&
    q.lvl2 != `SGS_RST_WORD && q.lvl2 < q.lvl1 |=> q.active != sgs_pkg::SET_ALT1)
    else $error("set 1 chosen with level 2 below level 1");

  // Inverted levels below polarity never give set 1
  chk_below_no_set1: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && src == `SGS_SRC_SPEED && src2 == `SGS_SRC2_SAME && below &&
    q.lvl2 > q.lvl1 |=> q.active != sgs_pkg::SET_ALT1)
    else $error("set 1 chosen with level 2 above level 1");

  // Speed over level 2 selects set 2
  chk_above_set2: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && src == `SGS_SRC_SPEED && src2 == `SGS_SRC2_SAME && !below &&
    q.lvl2 != `SGS_RST_WORD && q.lvl2 >= q.lvl1 && absVal(motorSpeed) > q.lvl2
    |=> q.active == sgs_pkg::SET_ALT2)
    else $error("set 2 not chosen above level 2");

  // At or above level 1 with below polarity stays base
  chk_below_base: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && src == `SGS_SRC_SPEED && src2 == `SGS_SRC2_SAME && below &&
    q.lvl2 <= q.lvl1 && absVal(motorSpeed) >= q.lvl1
    |=> q.active == sgs_pkg::SET_BASE)
    else $error("base not kept above level 1");

  // Bypassed switch loads the new bundle at once
  chk_bypass_switch: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && byp == `SGS_BYP_SWITCH && q.active == sgs_pkg::SET_BASE &&
    sel != sgs_pkg::SET_BASE |=> activeGains == $past(tgtGains))
    else $error("switch was filtered despite bypass");

  // Bypassed return loads base at once
  chk_bypass_return: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && ctrlTick && byp == `SGS_BYP_RETURN && q.active != sgs_pkg::SET_BASE &&
    sel == sgs_pkg::SET_BASE |=> activeGains == $past(baseGains))
    else $error("return was filtered despite bypass");

endmodule : sgs_gain_selector

// >>> rtl/sgs_defines.svh
/*
  Constants of the servo gain set selector: register offsets, field positions,
  codes and reset values. Assumes it is included by bare name from rtl/.
*/
// Function
// - Signal source on: alternate model gain used
// - Signal source on: alternate vibration parameters used
// - Word one/five bit 4 request sets
// - Status words bit 4 show active set
// - Above polarity, level2>=level1: graded switching
// - Above polarity, level2 zero: never set 2
// - Above polarity, level2<level1: never set 1
// - Below polarity, level2<=level1: graded switching
// - Below polarity, level2 zero: never set 2
// - Below polarity, level2>level1: never set 1
// - Bypass on switching: filtered return only
// - Bypass on return: filtered switching only
// - Command switching moves all thirteen together
// - Sources 2,3,4: frequency, droop, speed
// - Set 2 source: 0 off, 1 signal
// - Polarity 0 at/above or on, 1 below/off; the code compares strictly, so a level equal to level 1 never selects set 1
`ifndef SGS_DEFINES_SVH
`define SGS_DEFINES_SVH
`define SGS_OFF_CTRL1 16'h2D01
`define SGS_OFF_CTRL5 16'h2D05
`define SGS_OFF_STAT1 16'h2D11
`define SGS_OFF_STAT5 16'h2D15
`define SGS_OFF_CFG 16'h2D20
`define SGS_OFF_LVL1 16'h2D21
`define SGS_OFF_LVL2 16'h2D22
`define SGS_OFF_TC 16'h2D23
`define SGS_OFF_IRQST 16'h2D30
`define SGS_OFF_IRQMSK 16'h2D31
`define SGS_SW_BIT 4
`define SGS_CFG_SRC 2:0
`define SGS_CFG_POL 3
`define SGS_CFG_SRC2 5:4
`define SGS_CFG_BYP 7:6
`define SGS_TC1 3:0
`define SGS_TC2 7:4
`define SGS_SRC_SIG 3'h1
`define SGS_SRC_FREQ 3'h2
`define SGS_SRC_DROOP 3'h3
`define SGS_SRC_SPEED 3'h4
`define SGS_SRC2_OFF 2'h0
`define SGS_SRC2_SIG 2'h1
`define SGS_SRC2_SAME 2'h2
`define SGS_BYP_NONE 2'h0
`define SGS_BYP_SWITCH 2'h1
`define SGS_BYP_RETURN 2'h2
`define SGS_RST_WORD 16'h0000
`define SGS_RST_CFG 8'h00
`define SGS_RST_TCS 8'h00
`define SGS_RST_IRQ 3'h0
`define SGS_IRQ_ALT1 0
`define SGS_IRQ_ALT2 1
`define SGS_IRQ_BASE 2
`endif

// >>> rtl/sgs_pkg.sv
/*
  Types of the servo gain set selector: set enumeration, gain bundle, state.
  Assumes the widths of the defines header.
*/
package sgs_pkg;
  // Which of the three gain sets drives the loops
  typedef enum logic [1:0] {SET_BASE, SET_ALT1, SET_ALT2} sgs_set_e;
  // Thirteen 16-bit gains, index 1 is the model control gain
  typedef logic [12:0][15:0] sgs_gain_t;
  // Whole state of the selector
  typedef struct packed {
    logic [15:0] ctrl1;
    logic [15:0] ctrl5;
    logic [7:0] cfg;
    logic [15:0] lvl1;
    logic [15:0] lvl2;
    logic [7:0] tcs;
    sgs_set_e active;
    logic lastAlt2;
    sgs_gain_t gains;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic [15:0] rdata;
  } sgs_state_s;
endpackage : sgs_pkg

// >>> verif/sgs_motion_ctrl.sv
/*
  Motion controller model: register-bus master that writes control words
  and reads status words of the gain set selector.
  Assumes one clock; strobes change only just after a rising edge.
*/
`timescale 1ns/10ps
module sgs_motion_ctrl (
  input wire logic sys_clk,
  input wire logic [15:0] regRdata,
  output logic [15:0] regAddr,
  output logic [15:0] regWdata,
  output logic regWr,
  output logic regRd
);
  // Idle bus at time zero, strobes low
  initial begin
    regAddr = 16'hFFFF;
    regWdata = 16'h5A5A;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // One write cycle; set requests go out as bit 4 of the words
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    // Scramble released data so a stale word is never mistaken for a live one
    regWdata <= ~d;
  endtask : wr

  // One read cycle; data taken in the single cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdata;
  endtask : rd
endmodule : sgs_motion_ctrl

// >>> verif/sgs_gain_selector_tb.sv
/*
  Self-checking bench of the gain set selector: reset and register cases,
  table of switching cases, then tick, interrupt, filter-bypass and mid-run reset cases.
  Assumes tc 0 snaps gains to target on each tick.
*/
`timescale 1ns/10ps
`include "sgs_defines.svh"
module sgs_gain_selector_tb;
  // One case: config, levels, commands, devices, level value, expected set
  typedef struct {logic [7:0] cfg; logic [15:0] l1; logic [15:0] l2; logic [15:0] c1;
    logic [15:0] c5; logic i1; logic i2; logic [15:0] lv; logic [1:0] s;} sgs_row_s;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic ctrlTick = 1'b0;
  logic altSet1Input = 1'b0;
  logic altSet2Input = 1'b0;
  logic signed [15:0] motorSpeed = 16'h0000;
  logic signed [15:0] cmdFrequency = 16'h0000;
  logic signed [15:0] droopPulses = 16'h0000;
  logic [15:0] regAddr, regWdata, regRdata, rdv;
  logic regWr, regRd, altSet1ActiveFlag, altSet2ActiveFlag, irq;
  sgs_pkg::sgs_gain_t baseGains, set1Gains, set2Gains, activeGains, half;
  int errors = 0;
  int cmpCount = 0;
  sgs_row_s rows [0:27] = '{
    '{8'h11, 16'h0, 16'h0, 16'h0010, 16'h0, 1'b0, 1'b0, 16'h0, 2'h1},
    '{8'h11, 16'h0, 16'h0, 16'h0010, 16'h0010, 1'b0, 1'b0, 16'h0, 2'h2},
    '{8'h11, 16'h0, 16'h0, 16'h0, 16'h0010, 1'b0, 1'b0, 16'h0, 2'h2},
    '{8'h11, 16'h0, 16'h0, 16'hFFEF, 16'hFFEF, 1'b0, 1'b0, 16'h0, 2'h0},
    '{8'h11, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1, 1'b0, 16'h0, 2'h1},
    '{8'h11, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1, 1'b1, 16'h0, 2'h2},
    '{8'h09, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0, 2'h1},
    '{8'h09, 16'h0, 16'h0, 16'h0010, 16'h0, 1'b0, 1'b0, 16'h0, 2'h0},
    '{8'h24, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0096, 2'h1},
    '{8'h24, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'h00FA, 2'h2},
    '{8'h24, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0064, 2'h0},
    '{8'h24, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'hFF6A, 2'h1},
    '{8'h24, 16'h0064, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 16'h00FA, 2'h1},
    '{8'h24, 16'h00C8, 16'h0064, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0096, 2'h2},
    '{8'h24, 16'h00C8, 16'h0064, 16'h0, 16'h0, 1'b0, 1'b0, 16'h00FA, 2'h2},
    '{8'h24, 16'h00C8, 16'h0064, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0032, 2'h0},
    '{8'h2C, 16'h00C8, 16'h0064, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0032, 2'h2},
    '{8'h2C, 16'h00C8, 16'h0064, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0096, 2'h1},
    '{8'h2C, 16'h00C8, 16'h0064, 16'h0, 16'h0, 1'b0, 1'b0, 16'h00C8, 2'h0},
    '{8'h2C, 16'h00C8, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0096, 2'h1},
    '{8'h2C, 16'h00C8, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 16'h00FA, 2'h0},
    '{8'h2C, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0032, 2'h2},
    '{8'h2C, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0096, 2'h2},
    '{8'h22, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'h0096, 2'h1},
    '{8'h23, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'hFF06, 2'h2},
    '{8'h04, 16'h0064, 16'h00C8, 16'h0, 16'h0, 1'b0, 1'b0, 16'h00FA, 2'h1},
    '{8'h14, 16'h0064, 16'h00C8, 16'h0, 16'h0010, 1'b0, 1'b0, 16'h0032, 2'h2},
    '{8'h00, 16'h0, 16'h0, 16'h0010, 16'h0, 1'b0, 1'b0, 16'h0, 2'h0}};

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  sgs_motion_ctrl u_sgs_motion_ctrl (.sys_clk(sys_clk), .regRdata(regRdata),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd));

  sgs_gain_selector u_sgs_gain_selector (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .ctrlTick(ctrlTick), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .altSet1Input(altSet1Input),
    .altSet2Input(altSet2Input), .motorSpeed(motorSpeed), .cmdFrequency(cmdFrequency),
    .droopPulses(droopPulses), .baseGains(baseGains), .set1Gains(set1Gains),
    .set2Gains(set2Gains), .activeGains(activeGains), .altSet1ActiveFlag(altSet1ActiveFlag),
    .altSet2ActiveFlag(altSet2ActiveFlag), .irq(irq));

  // Distinct gain per set and index, so a swapped lane shows
  initial begin
    for (int i = 0; i < 13; i++) begin
      baseGains[i] = 16'h1000 + 16'(i);
      set1Gains[i] = 16'h2000 + 16'(i);
      set2Gains[i] = 16'h3000 + 16'(i);
      half[i] = 16'h1800 + 16'(i);
    end
  end

  // Compare and count
  task automatic chk(input string nm, input logic [207:0] seen, input logic [207:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Read a register and compare
  task automatic rchk(input logic [15:0] a, input logic [15:0] e, input string nm);
    u_sgs_motion_ctrl.rd(a, rdv);
    chk(nm, rdv, e);
  endtask : rchk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_sgs_motion_ctrl.wr(a, d);
  endtask : wr

  // One control-loop pulse; outputs settle just after the taking edge
  task automatic tick();
    @(posedge sys_clk);
    ctrlTick <= 1'b1;
    @(posedge sys_clk);
    ctrlTick <= 1'b0;
    #1;
  endtask : tick

  // Gains, flags and both status words for one expected set
  task automatic chk_set(input logic [1:0] s);
    chk("gains", activeGains, (s == 2'h1) ? set1Gains : (s == 2'h2) ? set2Gains : baseGains);
    chk("flag1", altSet1ActiveFlag, s == 2'h1);
    chk("flag2", altSet2ActiveFlag, s == 2'h2);
    rchk(`SGS_OFF_STAT1, {11'h0, s == 2'h1, 4'h0}, "status1");
    rchk(`SGS_OFF_STAT5, {11'h0, s == 2'h2, 4'h0}, "status5");
  endtask : chk_set

  // Verdict, the one exit of the run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    chk("rst gains", activeGains, 208'h0);
    chk("rst flags", {irq, altSet1ActiveFlag, altSet2ActiveFlag}, 3'h0);
    // Register access kinds, stand time, refused places
    wr(`SGS_OFF_CTRL1, 16'h1234);
    rchk(`SGS_OFF_CTRL1, 16'h1234, "ctrl1 rw");
    @(posedge sys_clk);
    #1;
    chk("rdata stands", regRdata, 16'h0000);
    wr(`SGS_OFF_STAT1, 16'hFFFF);
    rchk(`SGS_OFF_STAT1, 16'h0000, "status ro");
    rchk(16'h2D40, 16'h0000, "unmapped");
    // Table of switching cases
    foreach (rows[k]) begin
      wr(`SGS_OFF_CFG, {8'h00, rows[k].cfg});
      wr(`SGS_OFF_LVL1, rows[k].l1);
      wr(`SGS_OFF_LVL2, rows[k].l2);
      wr(`SGS_OFF_CTRL1, rows[k].c1);
      wr(`SGS_OFF_CTRL5, rows[k].c5);
      altSet1Input <= rows[k].i1;
      altSet2Input <= rows[k].i2;
      // Only the chosen source sees the level; the others read zero
      motorSpeed <= (rows[k].cfg[2:0] == `SGS_SRC_SPEED) ? rows[k].lv : 16'h0000;
      cmdFrequency <= (rows[k].cfg[2:0] == `SGS_SRC_FREQ) ? rows[k].lv : 16'h0000;
      droopPulses <= (rows[k].cfg[2:0] == `SGS_SRC_DROOP) ? rows[k].lv : 16'h0000;
      tick();
      chk_set(rows[k].s);
    end
    // Commands alone change nothing until a tick; ce low freezes the tick too
    wr(`SGS_OFF_CFG, 16'h0011);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("no tick", {altSet1ActiveFlag, altSet2ActiveFlag}, 2'h0);
    ce <= 1'b0;
    tick();
    ce <= 1'b1;
    chk("ce low", activeGains, baseGains);
    // Interrupts: sticky, masked, write-one-clear
    wr(`SGS_OFF_IRQST, 16'h0007);
    wr(`SGS_OFF_IRQMSK, 16'h0000);
    rchk(`SGS_OFF_IRQST, 16'h0000, "irq clear");
    wr(`SGS_OFF_CTRL5, 16'h0010);
    tick();
    chk("irq masked", irq, 1'b0);
    rchk(`SGS_OFF_IRQST, 16'h0002, "irq set2");
    wr(`SGS_OFF_IRQMSK, 16'h0002);
    #1;
    chk("irq on", irq, 1'b1);
    wr(`SGS_OFF_IRQST, 16'h0002);
    #1;
    chk("irq w1c", irq, 1'b0);
    wr(`SGS_OFF_IRQMSK, 16'h0007);
    // Both commands must drop, or set 1 would be entered instead of base
    wr(`SGS_OFF_CTRL1, 16'h0000);
    wr(`SGS_OFF_CTRL5, 16'h0000);
    tick();
    chk("irq base", irq, 1'b1);
    rchk(`SGS_OFF_IRQST, 16'h0004, "irq ret");
    // Bypass on switching: jump in, half step back out
    wr(`SGS_OFF_CFG, 16'h0051);
    wr(`SGS_OFF_TC, 16'h0011);
    wr(`SGS_OFF_CTRL1, 16'h0010);
    tick();
    chk("byp in", activeGains, set1Gains);
    wr(`SGS_OFF_CTRL1, 16'h0000);
    tick();
    chk("flt out", activeGains, half);
    wr(`SGS_OFF_TC, 16'h0000);
    tick();
    chk("snap base", activeGains, baseGains);
    // Bypass on return: half step in, jump back out
    wr(`SGS_OFF_CFG, 16'h0091);
    wr(`SGS_OFF_TC, 16'h0011);
    wr(`SGS_OFF_CTRL1, 16'h0010);
    tick();
    chk("flt in", activeGains, half);
    wr(`SGS_OFF_CTRL1, 16'h0000);
    tick();
    chk("byp out", activeGains, baseGains);
    // Mid-run reset clears outputs and registers; irq is high going in
    @(posedge sys_clk);
    nrst <= 1'b0;
    #1;
    chk("mid rst gains", activeGains, 208'h0);
    chk("mid rst flags", {irq, altSet1ActiveFlag, altSet2ActiveFlag}, 3'h0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    rchk(`SGS_OFF_CFG, 16'h0000, "mid rst cfg");
    rchk(`SGS_OFF_IRQMSK, 16'h0000, "mid rst mask");
    finish_test();
  end
endmodule : sgs_gain_selector_tb
